// ===== core/sdi_pkg.sv
// Constants, types and register layout for the storage discharge and isolation control.
// Assumes a single 250 MHz clock and a synchronous, active-high reset.
package sdi_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned HICCUP_TIME_MS = 250;
  localparam int unsigned STARTUP_TIME_MS = 250;
  localparam logic [7:0] HICCUP_TICKS = 8'(HICCUP_TIME_MS * 1000 / TICK_PERIOD_US);
  localparam logic [7:0] STARTUP_TICKS = 8'(STARTUP_TIME_MS * 1000 / TICK_PERIOD_US);

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] ADDR_STORAGE_DISCHARGE_CONFIG = 8'h2A;
  localparam logic [7:0] ADDR_ISOLATION_FET_OPTIONS = 8'h34;
  localparam logic [7:0] ADDR_DISCHARGE_AND_ISOLATION_CONTROL = 8'hEB;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned POS_PG_THRESHOLD_LSB = 0;
  localparam int unsigned POS_SINK_ENABLE = 4;
  localparam int unsigned POS_RETRY_SINGLE = 0;
  localparam int unsigned POS_MANUAL_FET = 1;
  localparam int unsigned POS_SS_CURRENT_LSB = 2;
  localparam int unsigned POS_FET_ON = 0;
  localparam int unsigned POS_DISCHARGE_REQ = 1;
  localparam int unsigned POS_PIN_DISCHARGE_EN = 2;
  localparam int unsigned POS_DISCHARGE_DONE = 3;
  localparam int unsigned POS_FORCED_SHUTDOWN = 4;
  localparam int unsigned POS_ISO_UV_FAULT = 5;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_STORAGE_DISCHARGE_CONFIG = 8'h00;
  localparam logic [7:0] RST_ISOLATION_FET_OPTIONS = 8'h00;
  localparam logic [7:0] RST_DISCHARGE_CONTROL = 8'h00;

  // ==========================================================================
  // Power-good threshold decode, per mille
  // ==========================================================================
  localparam logic [9:0] PG_BASE_LOW_PM = 10'd905;
  localparam logic [9:0] PG_BASE_HIGH_PM = 10'd945;
  localparam logic [9:0] PG_STEP_PM = 10'd5;

  typedef enum logic [3:0] {
    SDI_POR, SDI_SOFT_START, SDI_FET_ON, SDI_SUPPLEMENT, SDI_HICCUP, SDI_SUPPL_DISABLE,
    SDI_DIS_BUCK_OFF, SDI_DIS_ISOLATE, SDI_DIS_SINK
  } sdi_state_e;

  typedef enum logic [1:0] {
    SDI_CAUSE_POWER, SDI_CAUSE_DISCHARGE, SDI_CAUSE_FORCED
  } sdi_cause_e;

  // Comparator and detector levels from the analog stages
  typedef struct packed {
    logic vin_uv;
    logic bus_uv;
    logic storage_uv;
    logic power_loss;
    logic fet_settled;
    logic fet_overcurrent;
    logic sink_current_low;
  } sdi_sense_s;

  // Enables driven into the analog stages
  typedef struct packed {
    logic efuse_on;
    logic storage_buck_on;
    logic boost_on;
    logic fet_soft_start;
    logic fet_full_on;
    logic fet_limit_2a;
    logic sink_storage_on;
    logic sink_bus_on;
  } sdi_drive_s;

endpackage

// ===== core/sdi_sync.sv
// Two-flop synchroniser for a level from a pin.
// Assumes the pin is quiet compared with the clock.
`timescale 1ns/1ps
module sdi_sync import sdi_pkg::*; #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;

  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sdi_sync

// ===== core/sdi_tick.sv
// Divider that makes a one-cycle enable pulse every PERIOD cycles.
// Assumes PERIOD is at least 2.
`timescale 1ns/1ps
module sdi_tick import sdi_pkg::*; #(
  parameter int unsigned PERIOD = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);

  logic [31:0] count;

  always_ff @(posedge clock) begin
    if (srst || restart) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count == 32'(PERIOD - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule // sdi_tick

// ===== core/sdi_ctrl.sv
// Storage power-good decode, full storage discharge and isolation FET sequencing.
// Assumes a register port from the I2C slave and comparators that are synchronous.
//
// Notes on behaviour
// - Threshold code: upper bit picks 90.5% or 94.5% base, lower bits add 0.5%.
// - Storage power-good is high only while storage level exceeds the selected threshold.
// - Sink enable set on entering POR turns on both 50mA sinks.
// - Supplement state turns on the storage buck to feed the bus rail.
// - Writing 1 to the discharge bit starts a discharge; the bit resets to 0.
// - With pin enable set, a low discharge pin starts the same discharge.
// - Discharge turns off the eFuse path and also the buck, boost and FET.
// - Discharge or forced off turns off eFuse, buck, boost, FET; sinks if enabled.
// - Discharge order: buck off, then boost and FET off, then sinks on.
// - Done bit set once the sink current drops below 10mA; with sinks disabled, once the bus is undervoltage.
// - When discharge stops, request bit clears, enter POR, then soft start again.
// - Discharge ignores input recovery; restart only after done is set.
// - Soft start charges at programmed current until the FET voltage is near zero.
// - After soft start the FET is fully on with a 2A limit.
// - Startup not done in 250ms is a fault; FET off 250ms, then retry.
// - Single-retry option stops after one failed start; else retry forever.
// - FET current at 2A in the FET-on state turns it off, flags a fault and pulls the alert low.
// - After 250ms off the FET restarts soft start; persisting fault trips again.
// - Both hiccups are supplement-disable periods.
`timescale 1ns/1ps
module sdi_ctrl import sdi_pkg::*; #(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic discharge_pin_low,
  input wire logic [9:0] storage_level_pm,
  input wire sdi_sense_s sense,
  output sdi_drive_s drive,
  output logic [2:0] fet_ss_current,
  output logic storage_pg,
  output logic supplement_disabled,
  output logic fault_alert_low
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic [9:0] pg_threshold_pm(input logic [3:0] code);
    logic [9:0] base;
    base = code[3] ? PG_BASE_HIGH_PM : PG_BASE_LOW_PM;
    return 10'(base + PG_STEP_PM * {7'h00, code[2:0]});
  endfunction

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
    return reg_write && (addr == offset);
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [3:0] storage_pg_threshold;
  logic sink_discharge_enable;
  logic isolation_retry_single;
  logic manual_fet_mode;
  logic fet_on_bit;
  logic discharge_req;
  logic pin_discharge_en;
  logic discharge_done;
  logic forced_shutdown;
  logic iso_uv_fault;

  sdi_state_e state;
  sdi_state_e next_state;
  sdi_cause_e por_cause;
  logic sinks_armed;
  logic [7:0] ticks;
  logic tick;
  logic pin_low_sync;
  logic start_discharge;
  logic discharge_entry;
  logic discharge_finish;
  logic state_change;
  logic in_discharge;

  sdi_sync #(
    .RESET_LEVEL(1'b1)
  ) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in(discharge_pin_low),
    .sync_out(pin_low_sync)
  );

  sdi_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .clock(clock),
    .srst(srst),
    .restart(state_change),
    .tick(tick)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      storage_pg_threshold <= RST_STORAGE_DISCHARGE_CONFIG[3:0];
      sink_discharge_enable <= RST_STORAGE_DISCHARGE_CONFIG[POS_SINK_ENABLE];
    end else if (hits(reg_addr, ADDR_STORAGE_DISCHARGE_CONFIG)) begin
      storage_pg_threshold <= reg_wdata[POS_PG_THRESHOLD_LSB +: 4];
      sink_discharge_enable <= reg_wdata[POS_SINK_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      isolation_retry_single <= RST_ISOLATION_FET_OPTIONS[POS_RETRY_SINGLE];
      manual_fet_mode <= RST_ISOLATION_FET_OPTIONS[POS_MANUAL_FET];
      fet_ss_current <= RST_ISOLATION_FET_OPTIONS[POS_SS_CURRENT_LSB +: 3];
    end else if (hits(reg_addr, ADDR_ISOLATION_FET_OPTIONS)) begin
      isolation_retry_single <= reg_wdata[POS_RETRY_SINGLE];
      manual_fet_mode <= reg_wdata[POS_MANUAL_FET];
      fet_ss_current <= reg_wdata[POS_SS_CURRENT_LSB +: 3];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fet_on_bit <= RST_DISCHARGE_CONTROL[POS_FET_ON];
      pin_discharge_en <= RST_DISCHARGE_CONTROL[POS_PIN_DISCHARGE_EN];
    end else if (hits(reg_addr, ADDR_DISCHARGE_AND_ISOLATION_CONTROL)) begin
      fet_on_bit <= reg_wdata[POS_FET_ON];
      pin_discharge_en <= reg_wdata[POS_PIN_DISCHARGE_EN];
    end
  end

  // Request bit: a write of 1 sets, end of discharge clears; set wins
  always_ff @(posedge clock) begin
    if (srst) begin
      discharge_req <= RST_DISCHARGE_CONTROL[POS_DISCHARGE_REQ];
    end else if (hits(reg_addr, ADDR_DISCHARGE_AND_ISOLATION_CONTROL)
                 && reg_wdata[POS_DISCHARGE_REQ]) begin
      discharge_req <= 1'b1;
    end else if (discharge_finish) begin
      discharge_req <= 1'b0;
    end
  end

  // Forced power-off is taken once, then clears itself
  always_ff @(posedge clock) begin
    if (srst) begin
      forced_shutdown <= RST_DISCHARGE_CONTROL[POS_FORCED_SHUTDOWN];
    end else if (hits(reg_addr, ADDR_DISCHARGE_AND_ISOLATION_CONTROL)
                 && reg_wdata[POS_FORCED_SHUTDOWN]) begin
      forced_shutdown <= 1'b1;
    end else if (state == SDI_POR && por_cause == SDI_CAUSE_FORCED) begin
      forced_shutdown <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      discharge_done <= RST_DISCHARGE_CONTROL[POS_DISCHARGE_DONE];
    end else if (discharge_entry) begin
      discharge_done <= 1'b0;
    end else if (discharge_finish) begin
      discharge_done <= 1'b1;
    end
  end

  // Fault sticks until software writes 1; a new trip wins over the clear
  always_ff @(posedge clock) begin
    if (srst) begin
      iso_uv_fault <= RST_DISCHARGE_CONTROL[POS_ISO_UV_FAULT];
    end else if (state == SDI_FET_ON && sense.fet_overcurrent) begin
      iso_uv_fault <= 1'b1;
    end else if (hits(reg_addr, ADDR_DISCHARGE_AND_ISOLATION_CONTROL)
                 && reg_wdata[POS_ISO_UV_FAULT]) begin
      iso_uv_fault <= 1'b0;
    end
  end

  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      ADDR_STORAGE_DISCHARGE_CONFIG: begin
        reg_rdata[POS_PG_THRESHOLD_LSB +: 4] = storage_pg_threshold;
        reg_rdata[POS_SINK_ENABLE] = sink_discharge_enable;
      end
      ADDR_ISOLATION_FET_OPTIONS: begin
        reg_rdata[POS_RETRY_SINGLE] = isolation_retry_single;
        reg_rdata[POS_MANUAL_FET] = manual_fet_mode;
        reg_rdata[POS_SS_CURRENT_LSB +: 3] = fet_ss_current;
      end
      ADDR_DISCHARGE_AND_ISOLATION_CONTROL: begin
        reg_rdata[POS_FET_ON] = fet_on_bit;
        reg_rdata[POS_DISCHARGE_REQ] = discharge_req;
        reg_rdata[POS_PIN_DISCHARGE_EN] = pin_discharge_en;
        reg_rdata[POS_DISCHARGE_DONE] = discharge_done;
        reg_rdata[POS_FORCED_SHUTDOWN] = forced_shutdown;
        reg_rdata[POS_ISO_UV_FAULT] = iso_uv_fault;
      end
      default: reg_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Power-good
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      storage_pg <= 1'b0;
    end else begin
      storage_pg <= storage_level_pm > pg_threshold_pm(storage_pg_threshold);
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign in_discharge = state inside {SDI_DIS_BUCK_OFF, SDI_DIS_ISOLATE, SDI_DIS_SINK};
  assign start_discharge = discharge_req || (pin_discharge_en && !pin_low_sync);
  assign discharge_entry = next_state == SDI_DIS_BUCK_OFF && state != SDI_DIS_BUCK_OFF;
  assign discharge_finish = state == SDI_DIS_SINK && next_state == SDI_POR;
  assign state_change = next_state != state;

  always_comb begin
    next_state = state;
    unique case (state)
      SDI_POR: begin
        // Exit conditions depend on why POR was entered
        unique case (por_cause)
          SDI_CAUSE_FORCED: begin
            if (sense.bus_uv && sense.storage_uv && sense.vin_uv) begin
              next_state = SDI_POR;
            end
          end
          SDI_CAUSE_DISCHARGE: begin
            if (!sense.vin_uv && !forced_shutdown && sense.bus_uv) begin
              next_state = SDI_SOFT_START;
            end
          end
          default: begin
            if (!sense.vin_uv && !forced_shutdown) begin
              next_state = SDI_SOFT_START;
            end
          end
        endcase
      end
      SDI_SOFT_START: begin
        if (sense.fet_settled) begin
          next_state = SDI_FET_ON;
        end else if (tick && ticks == STARTUP_TICKS - 8'h01) begin
          next_state = isolation_retry_single ? SDI_SUPPL_DISABLE : SDI_HICCUP;
        end
      end
      SDI_FET_ON: begin
        if (sense.fet_overcurrent) begin
          next_state = SDI_HICCUP;
        end else if (sense.power_loss) begin
          next_state = SDI_SUPPLEMENT;
        end
      end
      SDI_SUPPLEMENT: begin
        if (!sense.power_loss) begin
          next_state = SDI_FET_ON;
        end
      end
      SDI_HICCUP: begin
        if (tick && ticks == HICCUP_TICKS - 8'h01) begin
          next_state = SDI_SOFT_START;
        end
      end
      SDI_SUPPL_DISABLE: next_state = SDI_SUPPL_DISABLE;
      SDI_DIS_BUCK_OFF: next_state = SDI_DIS_ISOLATE;
      SDI_DIS_ISOLATE: next_state = SDI_DIS_SINK;
      SDI_DIS_SINK: begin
        // Input recovery is ignored here
        if (sink_discharge_enable ? sense.sink_current_low : sense.bus_uv) begin
          next_state = SDI_POR;
        end
      end
      default: next_state = SDI_POR;
    endcase
    if (!in_discharge && !(state == SDI_POR && por_cause == SDI_CAUSE_FORCED)) begin
      if (forced_shutdown) begin
        next_state = SDI_POR;
      end else if (start_discharge && state != SDI_POR) begin
        next_state = SDI_DIS_BUCK_OFF;
      end else if (sense.vin_uv && state != SDI_SUPPLEMENT && state != SDI_POR
                   && state != SDI_SUPPL_DISABLE) begin
        next_state = sense.power_loss ? next_state : SDI_POR;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= SDI_POR;
    end else begin
      state <= next_state;
    end
  end

  // Remember why POR was entered and arm sinks at that moment
  always_ff @(posedge clock) begin
    if (srst) begin
      por_cause <= SDI_CAUSE_POWER;
      sinks_armed <= 1'b0;
    end else if (next_state == SDI_POR && state != SDI_POR) begin
      por_cause <= forced_shutdown ? SDI_CAUSE_FORCED
                   : (in_discharge ? SDI_CAUSE_DISCHARGE : SDI_CAUSE_POWER);
      sinks_armed <= sink_discharge_enable;
    end else if (state == SDI_POR && por_cause == SDI_CAUSE_FORCED
                 && sense.bus_uv && sense.storage_uv && sense.vin_uv) begin
      por_cause <= SDI_CAUSE_POWER;
      sinks_armed <= 1'b0;
    end else if (state == SDI_POR && por_cause != SDI_CAUSE_FORCED
                 && sense.bus_uv && sense.storage_uv) begin
      sinks_armed <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || state_change) begin
      ticks <= 8'h00;
    end else if (tick) begin
      ticks <= ticks + 8'h01;
    end
  end

  // ==========================================================================
  // Stage enables
  // ==========================================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      drive <= '0;
    end else begin
      drive <= '0;
      unique case (next_state)
        SDI_SOFT_START: begin
          drive.efuse_on <= 1'b1;
          drive.fet_soft_start <= !manual_fet_mode || fet_on_bit;
        end
        SDI_FET_ON: begin
          drive.efuse_on <= 1'b1;
          drive.fet_full_on <= !manual_fet_mode || fet_on_bit;
          drive.fet_limit_2a <= 1'b1;
          drive.boost_on <= !manual_fet_mode || fet_on_bit;
        end
        SDI_SUPPLEMENT: begin
          drive.storage_buck_on <= 1'b1;
          drive.fet_full_on <= 1'b1;
          drive.fet_limit_2a <= 1'b1;
        end
        SDI_HICCUP, SDI_SUPPL_DISABLE: begin
          drive.efuse_on <= 1'b1;
        end
        SDI_DIS_BUCK_OFF: begin
          drive.fet_full_on <= 1'b1;
          drive.fet_limit_2a <= 1'b1;
          drive.boost_on <= 1'b1;
        end
        SDI_DIS_ISOLATE: drive <= '0;
        SDI_DIS_SINK: begin
          drive.sink_storage_on <= sink_discharge_enable;
          drive.sink_bus_on <= sink_discharge_enable;
        end
        SDI_POR: begin
          drive.sink_storage_on <= sinks_armed || (state != SDI_POR && sink_discharge_enable);
          drive.sink_bus_on <= sinks_armed || (state != SDI_POR && sink_discharge_enable);
        end
        default: drive <= '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      supplement_disabled <= 1'b0;
      fault_alert_low <= 1'b1;
    end else begin
      supplement_disabled <= next_state inside {SDI_HICCUP, SDI_SUPPL_DISABLE};
      fault_alert_low <= !(iso_uv_fault || (state == SDI_FET_ON && sense.fet_overcurrent));
    end
  end

endmodule // sdi_ctrl

// ===== testbench/sdi_ctrl_chk.sv
// Port-level assertions for sdi_ctrl.
// Assumes 0x2A changes only through the register write port.
`timescale 1ns/1ps
module sdi_ctrl_chk import sdi_pkg::*; #(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [9:0] storage_level_pm,
  input wire sdi_sense_s sense,
  input wire sdi_drive_s drive,
  input wire logic storage_pg,
  input wire logic supplement_disabled,
  input wire logic fault_alert_low
);
  localparam int LIM = 250 * TICK_PERIOD;
  logic [7:0] cfg;
  logic [9:0] thr;
  int ss_cnt;
  int sd_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Shadow threshold and phase lengths
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg <= 8'h00;
    end else if (reg_write && reg_addr == 8'h2A) begin
      cfg <= reg_wdata;
    end
  end
  always_ff @(posedge clock) begin
    ss_cnt <= (srst || !drive.fet_soft_start) ? 0 : ss_cnt + 1;
    sd_cnt <= (srst || !supplement_disabled) ? 0 : sd_cnt + 1;
  end
  assign thr = (cfg[3] ? 10'h3B1 : 10'h389) + 10'h005 * cfg[2:0];
  AST_PG_LEVEL:
    assert property (!$past(reg_write) && !$past(reg_write, 2) && !$past(srst)
      && $stable(storage_level_pm) |-> storage_pg == (storage_level_pm > thr))
      else $error("storage good disagrees with threshold");
  AST_FULL_LIMIT:
    assert property (drive.fet_full_on |-> drive.fet_limit_2a) else $error("no 2A limit");
  AST_SINK_ALONE:
    assert property (drive.sink_storage_on |-> !(drive.efuse_on || drive.storage_buck_on
      || drive.boost_on || drive.fet_full_on)) else $error("sink with stage on");
  AST_SINK_ORDER:
    assert property ($rose(drive.sink_storage_on) |-> !$past(drive.storage_buck_on)
      && !$past(drive.fet_full_on)) else $error("sink before isolation");
  AST_TRIP_OFF:
    assert property (sense.fet_overcurrent && drive.fet_full_on && drive.efuse_on
      && !drive.storage_buck_on |=> !drive.fet_full_on && !fault_alert_low)
      else $error("trip not handled");
  AST_HICCUP_FET_OFF:
    assert property (supplement_disabled |-> !drive.fet_full_on && !drive.fet_soft_start)
      else $error("fet on in hiccup");
  AST_STARTUP_BOUND:
    assert property (ss_cnt <= LIM + TICK_PERIOD + 4) else $error("soft start too long");
  AST_HICCUP_LENGTH:
    assert property ($fell(supplement_disabled) && !$past(srst) |-> sd_cnt >= LIM - TICK_PERIOD)
      else $error("hiccup too short");
endmodule // sdi_ctrl_chk

bind sdi_ctrl sdi_ctrl_chk #(.TICK_PERIOD(TICK_PERIOD)) sdi_ctrl_chk_inst (
  .clock(clock), .srst(srst), .reg_write(reg_write), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .storage_level_pm(storage_level_pm), .sense(sense),
  .drive(drive), .storage_pg(storage_pg), .supplement_disabled(supplement_disabled),
  .fault_alert_low(fault_alert_low));

// ===== testbench/sdi_plant.sv
// Behavioural analog stages and rails around sdi_ctrl.
// Assumes the bench sets supply and fault conditions.
`timescale 1ns/1ps
module sdi_plant import sdi_pkg::*; (
  input wire logic clock,
  input wire sdi_drive_s drive,
  input wire logic vin_low,
  input wire logic pwr_fail,
  input wire logic short_ckt,
  input wire logic slow,
  output sdi_sense_s sense
);
  logic [7:0] ss_cnt = 8'h00;
  logic [7:0] sk_cnt = 8'h00;
  logic [7:0] off_cnt = 8'h00;
  // ==========================================================================
  // Rails charge and drain, in cycles
  always_ff @(posedge clock) begin
    ss_cnt <= drive.fet_soft_start ? ss_cnt + 8'(ss_cnt != 8'hFF) : 8'h00;
    sk_cnt <= drive.sink_storage_on ? sk_cnt + 8'(sk_cnt != 8'hFF) : 8'h00;
    off_cnt <= (drive == '0) ? off_cnt + 8'(off_cnt != 8'hFF) : 8'h00;
  end
  assign sense.vin_uv = vin_low;
  assign sense.power_loss = pwr_fail;
  // Huge bank never settles when slow
  assign sense.fet_settled = !slow && ss_cnt >= 8'h14;
  assign sense.fet_overcurrent = short_ckt && drive.fet_full_on;
  assign sense.sink_current_low = sk_cnt >= 8'h0C;
  assign sense.bus_uv = sense.sink_current_low || off_cnt >= 8'h0C;
  assign sense.storage_uv = sense.bus_uv;
endmodule // sdi_plant

// ===== testbench/storage_discharge_isolation_ctrl_bench.sv
// Self-checking bench: sdi_ctrl with the analog model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module storage_discharge_isolation_ctrl_bench import sdi_pkg::*;;
  localparam int TP = 4;
  localparam int SINK = 1, FULL = 3, SS = 4, BUCK = 6, SD = 8;
  logic clock = 1'b0, srst = 1'b1, reg_write = 1'b0, discharge_pin_low = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0] storage_level_pm = 10'h000, lvl;
  logic vin_low = 1'b1, pwr_fail = 1'b0, short_ckt = 1'b0, slow = 1'b0;
  logic [2:0] fet_ss_current, code;
  logic storage_pg, supplement_disabled, fault_alert_low;
  sdi_sense_s sense;
  sdi_drive_s drive;
  logic [8:0] obs;
  logic [31:0] lfsr = 32'h03A65EF4;
  int n_fail = 0, num_checks = 0, i;
  assign obs = {supplement_disabled, drive};
  sdi_ctrl #(.TICK_PERIOD(TP)) sdi_ctrl_inst (.clock(clock), .srst(srst),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .discharge_pin_low(discharge_pin_low), .storage_level_pm(storage_level_pm), .sense(sense),
    .drive(drive), .fet_ss_current(fet_ss_current), .storage_pg(storage_pg),
    .supplement_disabled(supplement_disabled), .fault_alert_low(fault_alert_low));
  sdi_plant sdi_plant_inst (.clock(clock), .drive(drive), .vin_low(vin_low),
    .pwr_fail(pwr_fail), .short_ckt(short_ckt), .slow(slow), .sense(sense));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [9:0] thr(input logic [3:0] c);
    return (c[3] ? 10'h3B1 : 10'h389) + 10'h005 * c[2:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Single cycle strobe; callers never write twice back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    #1;
    check(reg_rdata, exp);
    step(1);
  endtask
  task automatic wt(input int k, input logic v, input int lim);
    for (i = 0; i < lim && obs[k] !== v; i++) step(1);
    check(obs[k], v);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    forever #2 clock = ~clock;
  end
  initial begin
    #(30000 * 4);
    n_fail++;
    finish_test();
  end
  initial begin
    step(8);
    srst = 1'b0;
    check(fault_alert_low, 1'b1);
    rd(8'h2A, 8'h00);
    rd(8'h34, 8'h00);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    wr(8'hEB, 8'h08);
    rd(8'hEB, 8'h00);
    $display("reset done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h2A, 8'(c));
      storage_level_pm = thr(4'(c));
      step(3);
      check(storage_pg, 1'b0);
      storage_level_pm = thr(4'(c)) + 10'h001;
      step(3);
      check(storage_pg, 1'b1);
      lfsr = rnd(lfsr);
      lvl = 10'h370 + 10'(lfsr[6:0]);
      storage_level_pm = lvl;
      step(3);
      check(storage_pg, lvl > thr(4'(c)));
    end
    $display("threshold done");
    lfsr = rnd(lfsr);
    code = lfsr[2:0];
    wr(8'h34, {3'h0, code, 2'h0});
    check(fet_ss_current, code);
    vin_low = 1'b0;
    wt(SS, 1'b1, 5);
    check(drive.efuse_on, 1'b1);
    wt(FULL, 1'b1, 40);
    check(32'(i >= 18), 1);
    check(drive.boost_on, 1'b1);
    wr(8'h2A, 8'h10);
    pwr_fail = 1'b1;
    wt(BUCK, 1'b1, 5);
    vin_low = 1'b1;
    $display("startup done");
    wr(8'hEB, 8'h02);
    wt(BUCK, 1'b0, 5);
    check(drive.fet_full_on, 1'b1);
    step(1);
    check(drive, 8'h00);
    step(1);
    check(drive, 8'h03);
    vin_low = 1'b0;
    pwr_fail = 1'b0;
    step(4);
    check(drive.sink_storage_on, 1'b1);
    wt(SINK, 1'b0, 30);
    rd(8'hEB, 8'h08);
    wt(SS, 1'b1, 30);
    $display("register discharge done");
    wt(FULL, 1'b1, 40);
    wr(8'h2A, 8'h00);
    step(1);
    wr(8'hEB, 8'h04);
    discharge_pin_low = 1'b0;
    wt(FULL, 1'b0, 8);
    step(3);
    check(drive, 8'h00);
    check(reg_rdata[3], 1'b0);
    discharge_pin_low = 1'b1;
    wt(FULL, 1'b1, 80);
    $display("pin discharge done");
    wr(8'hEB, 8'h10);
    step(40);
    check(drive, 8'h00);
    vin_low = 1'b1;
    step(2);
    vin_low = 1'b0;
    wt(FULL, 1'b1, 80);
    short_ckt = 1'b1;
    step(2);
    check(drive.fet_full_on, 1'b0);
    check(fault_alert_low, 1'b0);
    check(supplement_disabled, 1'b1);
    check(reg_rdata[5], 1'b1);
    short_ckt = 1'b0;
    wt(SD, 1'b0, 1100);
    check(32'(i >= 990), 1);
    wt(SS, 1'b1, 3);
    wr(8'hEB, 8'h20);
    step(1);
    check(fault_alert_low, 1'b1);
    $display("overcurrent done");
    srst = 1'b1;
    slow = 1'b1;
    step(2);
    srst = 1'b0;
    wt(SS, 1'b1, 5);
    wt(SD, 1'b1, 1100);
    check(32'(i >= 990), 1);
    wt(SD, 1'b0, 1100);
    check(32'(i >= 990), 1);
    wt(SS, 1'b1, 3);
    wr(8'h34, 8'h01);
    wt(SD, 1'b1, 1100);
    step(1200);
    check(obs[SD], 1'b1);
    check(drive.fet_soft_start, 1'b0);
    $display("timeout done");
    finish_test();
  end
endmodule // storage_discharge_isolation_ctrl_bench
